// ==== core/xbc_cycle_ctrl.v ====
// external bus cycle sequencer with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "xbc_defines.vh"

module xbc_cycle_ctrl #(
  parameter ADDR_W = 24,
  parameter DATA_W = 16,
  parameter NUM_CS = 4
) (
  // clock, reset, enable
  input  wire               clk,
  input  wire               rst_n,
  input  wire               ce,
  // axi4-lite slave
  input  wire [7:0]         s_awaddr,
  input  wire               s_awvalid,
  output wire               s_awready,
  input  wire [31:0]        s_wdata,
  input  wire [3:0]         s_wstrb,
  input  wire               s_wvalid,
  output wire               s_wready,
  output reg  [1:0]         s_bresp,
  output reg                s_bvalid,
  input  wire               s_bready,
  input  wire [7:0]         s_araddr,
  input  wire               s_arvalid,
  output wire               s_arready,
  output reg  [31:0]        s_rdata,
  output reg  [1:0]         s_rresp,
  output reg                s_rvalid,
  input  wire               s_rready,
  // external bus control
  output reg  [NUM_CS-1:0]  chip_select_n,
  output reg                addr_latch_strobe,
  output reg                upper_byte_enable_n,
  output reg                read_strobe_n,
  output reg                write_low_n,
  output reg                write_high_n,
  output wire               bus_reference_clock_out,
  input  wire               ready_in,
  // address and data lines
  output reg  [ADDR_W-1:0]  address_lines,
  input  wire [DATA_W-1:0]  shared_addr_data_lines_in,
  output reg  [DATA_W-1:0]  shared_addr_data_lines_out,
  output reg                shared_addr_data_lines_oe,
  input  wire [DATA_W-1:0]  data_lines_in,
  output reg  [DATA_W-1:0]  data_lines_out,
  output reg                data_lines_oe
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_AB   = 6'h02;
  localparam [5:0] ST_C    = 6'h04;
  localparam [5:0] ST_D    = 6'h08;
  localparam [5:0] ST_E    = 6'h10;
  localparam [5:0] ST_F    = 6'h20;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [10:0]        ctrl_ff;
  reg [ADDR_W-1:0]  addr_ff;
  reg [DATA_W-1:0]  wdata_ff;
  reg [DATA_W-1:0]  rdata_ff;
  reg               done_ff;
  reg [13:0]        tcfg_ff [0:NUM_CS-1];
  reg [5:0]         state_ff;
  reg [5:0]         cnt_ff;
  reg               rwait_ff;
  reg               go_ff;
  reg               rdy_s1_ff;
  reg               rdy_s2_ff;
  reg               rdy_s3_ff;
  reg [DATA_W-1:0]  din_s1_ff;
  reg [DATA_W-1:0]  din_s2_ff;
  reg [7:0]         awaddr_ff;
  reg               aw_ok_ff;
  reg [31:0]        wd_ff;
  reg [3:0]         ws_ff;
  reg               w_ok_ff;
  integer           i;

  wire busy = ~state_ff[0];
  wire cfg_write  = ctrl_ff[`XBC_CTRL_WRITE];
  wire cfg_byte   = ctrl_ff[`XBC_CTRL_BYTE];
  wire cfg_upper  = ctrl_ff[`XBC_CTRL_UPPER];
  wire cfg_shared = ctrl_ff[`XBC_CTRL_SHARED];
  wire [1:0] cs_idx = ctrl_ff[`XBC_CTRL_CS_HI:`XBC_CTRL_CS_LO];

  // ----------------------------------------------------------------
  // reference clock out
  // ----------------------------------------------------------------
  // system clock gated by a flop so the pin is quiet until enabled
  assign bus_reference_clock_out = clk & ctrl_ff[`XBC_CTRL_CLKEN];

  // ----------------------------------------------------------------
  // phase lengths of the selected chip select
  // ----------------------------------------------------------------
  wire [13:0] tc = tcfg_ff[cs_idx];
  wire [2:0]  ab_raw = tc[`XBC_TC_AB_HI:`XBC_TC_AB_LO];
  reg  [2:0]  len_ab;
  // illegal codes fold down: 0 to 1, 3 and 4 to 2, 6 and 7 to 5
  always @* begin
    if (ab_raw == 3'h0)
      len_ab = 3'h1;
    else if (ab_raw < 3'h3)
      len_ab = ab_raw;
    else if (ab_raw < `XBC_AB_MAX)
      len_ab = 3'h2;
    else
      len_ab = `XBC_AB_MAX;
  end
  wire [1:0] len_c = tc[`XBC_TC_C_HI:`XBC_TC_C_LO];
  wire       len_d = tc[`XBC_TC_D];
  wire [5:0] len_e = {1'b0, tc[`XBC_TC_E_HI:`XBC_TC_E_LO]} + 6'h01;
  wire [1:0] len_f = tc[`XBC_TC_F_HI:`XBC_TC_F_LO];

  // ----------------------------------------------------------------
  // ready and read data synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
      rdy_s3_ff <= 1'b0;
      din_s1_ff <= {DATA_W{1'b0}};
      din_s2_ff <= {DATA_W{1'b0}};
    end else if (ce) begin
      rdy_s1_ff <= ready_in;
      rdy_s2_ff <= rdy_s1_ff;
      rdy_s3_ff <= rdy_s2_ff;
      din_s1_ff <= cfg_shared ? shared_addr_data_lines_in : data_lines_in;
      din_s2_ff <= din_s1_ff;
    end
  end

  // async mode looks one stage later, moving its sample point
  wire rdy_smp = ctrl_ff[`XBC_CTRL_RDYASY] ? rdy_s3_ff : rdy_s2_ff;
  wire rdy_act = ctrl_ff[`XBC_CTRL_RDYPOL] ? rdy_smp : ~rdy_smp;
  wire rdy_ok  = ~ctrl_ff[`XBC_CTRL_RDYEN] | rdy_act;

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  reg [5:0] nxt_state;
  reg [5:0] nxt_cnt;
  reg       nxt_rwait;
  reg       capture;

  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_rwait = 1'b0;
    capture   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (go_ff) begin
          nxt_state = ST_AB;
          nxt_cnt   = {3'h0, len_ab} - 6'h01;
        end
      end
      ST_AB: begin
        if (cnt_ff != 6'h00) begin
          nxt_cnt = cnt_ff - 6'h01;
        end else if (len_c != 2'h0) begin
          nxt_state = ST_C;
          nxt_cnt   = {4'h0, len_c} - 6'h01;
        end else if (len_d) begin
          nxt_state = ST_D;
          nxt_cnt   = 6'h00;
        end else begin
          nxt_state = ST_E;
          nxt_cnt   = len_e - 6'h01;
        end
      end
      ST_C: begin
        if (cnt_ff != 6'h00) begin
          nxt_cnt = cnt_ff - 6'h01;
        end else if (len_d) begin
          nxt_state = ST_D;
          nxt_cnt   = 6'h00;
        end else begin
          nxt_state = ST_E;
          nxt_cnt   = len_e - 6'h01;
        end
      end
      ST_D: begin
        nxt_state = ST_E;
        nxt_cnt   = len_e - 6'h01;
      end
      ST_E: begin
        // programmed access waits run out before ready is looked at
        if (cnt_ff != 6'h00) begin
          nxt_cnt = cnt_ff - 6'h01;
        end else if (!rdy_ok) begin
          nxt_rwait = 1'b1;
        end else begin
          capture = 1'b1;
          if (len_f != 2'h0) begin
            nxt_state = ST_F;
            nxt_cnt   = {4'h0, len_f} - 6'h01;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_F: begin
        if (cnt_ff != 6'h00)
          nxt_cnt = cnt_ff - 6'h01;
        else
          nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cnt   = 6'h00;
      end
    endcase
  end

  wire cyc_end = busy & (nxt_state == ST_IDLE);
  wire ns_cmd  = (nxt_state == ST_D) | (nxt_state == ST_E);
  wire ns_dat  = cfg_write & ~nxt_state[0] & ~nxt_state[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff                   <= ST_IDLE;
      cnt_ff                     <= 6'h00;
      rwait_ff                   <= 1'b0;
      rdata_ff                   <= {DATA_W{1'b0}};
      chip_select_n              <= {NUM_CS{1'b1}};
      addr_latch_strobe          <= 1'b0;
      upper_byte_enable_n        <= 1'b1;
      read_strobe_n              <= 1'b1;
      write_low_n                <= 1'b1;
      write_high_n               <= 1'b1;
      address_lines              <= {ADDR_W{1'b0}};
      shared_addr_data_lines_out <= {DATA_W{1'b0}};
      shared_addr_data_lines_oe  <= 1'b0;
      data_lines_out             <= {DATA_W{1'b0}};
      data_lines_oe              <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      rwait_ff <= nxt_rwait;
      if (capture && !cfg_write)
        rdata_ff <= din_s2_ff;
      chip_select_n <= {NUM_CS{1'b1}};
      if (!nxt_state[0])
        chip_select_n[cs_idx] <= 1'b0;
      addr_latch_strobe <= cfg_shared & (nxt_state == ST_AB);
      upper_byte_enable_n <= nxt_state[0] | (cfg_byte & ~cfg_upper);
      read_strobe_n <= ~(ns_cmd & ~cfg_write);
      write_low_n  <= ~((nxt_state == ST_E) & cfg_write &
                        ~(cfg_byte & cfg_upper));
      write_high_n <= ~((nxt_state == ST_E) & cfg_write &
                        (~cfg_byte | cfg_upper));
      address_lines <= addr_ff;
      // shared lines carry address first, then write data
      if (cfg_shared && nxt_state == ST_AB) begin
        shared_addr_data_lines_out <= addr_ff[DATA_W-1:0];
        shared_addr_data_lines_oe  <= 1'b1;
      end else begin
        shared_addr_data_lines_out <= wdata_ff;
        shared_addr_data_lines_oe  <= cfg_shared & ns_dat;
      end
      data_lines_out <= wdata_ff;
      data_lines_oe  <= ~cfg_shared & ns_dat;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  assign s_awready = ~aw_ok_ff & ~s_bvalid;
  assign s_wready  = ~w_ok_ff & ~s_bvalid;
  assign s_arready = ~s_rvalid;

  wire       wr_fire = aw_ok_ff & w_ok_ff & ~s_bvalid;
  wire [5:0] widx    = awaddr_ff[7:2];
  wire [5:0] ridx    = s_araddr[7:2];
  wire [7:0] tc0_ofs = `XBC_OFS_TCFG0;
  wire [7:0] tc3_ofs = `XBC_OFS_TCFG3;
  wire [5:0] tc0_idx = tc0_ofs[7:2];
  wire [5:0] tc3_idx = tc3_ofs[7:2];
  wire       w_tcfg  = (widx >= tc0_idx) & (widx <= tc3_idx);
  wire [1:0] w_tsel  = widx[1:0] - tc0_idx[1:0];
  wire       w_map   = w_tcfg | (awaddr_ff == `XBC_OFS_CTRL) |
                       (awaddr_ff == `XBC_OFS_ADDR) |
                       (awaddr_ff == `XBC_OFS_WDATA) |
                       (awaddr_ff == `XBC_OFS_RDATA) |
                       (awaddr_ff == `XBC_OFS_STATUS);
  wire [31:0] wmask  = {{8{ws_ff[3]}}, {8{ws_ff[2]}},
                        {8{ws_ff[1]}}, {8{ws_ff[0]}}};

  // register writes are ignored while a cycle is pending or running, except the STATUS done clear
  wire upd = wr_fire & ~busy & ~go_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      awaddr_ff <= 8'h00;
      wd_ff     <= 32'h0000_0000;
      ws_ff     <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `XBC_RESP_OKAY;
      ctrl_ff   <= `XBC_CTRL_RESET;
      addr_ff   <= {ADDR_W{1'b0}};
      wdata_ff  <= {DATA_W{1'b0}};
      go_ff     <= 1'b0;
      done_ff   <= 1'b0;
      for (i = 0; i < NUM_CS; i = i + 1)
        tcfg_ff[i] <= `XBC_TCFG_RESET;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_ok_ff <= 1'b1;
        wd_ff   <= s_wdata;
        ws_ff   <= s_wstrb;
      end
      if (wr_fire) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff  <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= w_map ? `XBC_RESP_OKAY : `XBC_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (state_ff == ST_IDLE && go_ff)
        go_ff <= 1'b0;
      if (upd && awaddr_ff == `XBC_OFS_CTRL) begin
        ctrl_ff <= (ctrl_ff & ~wmask[10:0]) | (wd_ff[10:0] & wmask[10:0]);
        if (ws_ff[0] && wd_ff[`XBC_CTRL_START])
          go_ff <= 1'b1;
      end
      if (upd && awaddr_ff == `XBC_OFS_ADDR)
        addr_ff <= (addr_ff & ~wmask[ADDR_W-1:0]) |
                   (wd_ff[ADDR_W-1:0] & wmask[ADDR_W-1:0]);
      if (upd && awaddr_ff == `XBC_OFS_WDATA)
        wdata_ff <= (wdata_ff & ~wmask[DATA_W-1:0]) |
                    (wd_ff[DATA_W-1:0] & wmask[DATA_W-1:0]);
      if (upd && w_tcfg)
        tcfg_ff[w_tsel] <= (tcfg_ff[w_tsel] & ~wmask[13:0]) |
                           (wd_ff[13:0] & wmask[13:0]);
      // a cycle finishing in the clearing cycle keeps the flag set
      if (cyc_end)
        done_ff <= 1'b1;
      else if (wr_fire && awaddr_ff == `XBC_OFS_STATUS && ws_ff[0] &&
               wd_ff[`XBC_STAT_DONE])
        done_ff <= 1'b0;
    end
  end

  reg [31:0] rd_mux;
  reg        rd_map;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_map = 1'b1;
    if (ridx >= tc0_idx && ridx <= tc3_idx)
      rd_mux = {18'h00000, tcfg_ff[ridx[1:0] - tc0_idx[1:0]]};
    else if (s_araddr == `XBC_OFS_CTRL)
      rd_mux = {21'h000000, ctrl_ff};
    else if (s_araddr == `XBC_OFS_ADDR)
      rd_mux = {{(32-ADDR_W){1'b0}}, addr_ff};
    else if (s_araddr == `XBC_OFS_WDATA)
      rd_mux = {{(32-DATA_W){1'b0}}, wdata_ff};
    else if (s_araddr == `XBC_OFS_RDATA)
      rd_mux = {{(32-DATA_W){1'b0}}, rdata_ff};
    else if (s_araddr == `XBC_OFS_STATUS)
      rd_mux = {29'h00000000, rwait_ff, done_ff, busy | go_ff};
    else
      rd_map = 1'b0;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= `XBC_RESP_OKAY;
    end else if (ce) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_mux;
        s_rresp  <= rd_map ? `XBC_RESP_OKAY : `XBC_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== core/xbc_defines.vh ====
// constants for the external bus cycle controller
//
// Summary of operation
// - every cycle runs phases AB, C, D, E, F in order; C, D and F are skipped when their length is zero
// - phase lengths come from chip-select timing registers
// - lengths limited to documented ranges per phase
// - READY may extend access phase, per configuration
// - READY active polarity is selectable
// - async READY gets an extra synchroniser stage
// - first sample point follows programmed phase lengths
// - inactive READY inserts one wait, resamples
// - active READY ends access, closing phases follow
// - async sample point later than sync one
// - minimum access waits elapse before READY evaluated
// - read data captured as read strobe rises
// - shared 16-line or split 24/16-line bus modes
// - reference clock out is system clock, enabled
`ifndef XBC_DEFINES_VH
`define XBC_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define XBC_OFS_CTRL    8'h00
`define XBC_OFS_ADDR    8'h04
`define XBC_OFS_WDATA   8'h08
`define XBC_OFS_RDATA   8'h0C
`define XBC_OFS_STATUS  8'h10
`define XBC_OFS_TCFG0   8'h14
`define XBC_OFS_TCFG3   8'h20

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define XBC_CTRL_START   0
`define XBC_CTRL_WRITE   1
`define XBC_CTRL_BYTE    2
`define XBC_CTRL_UPPER   3
`define XBC_CTRL_SHARED  4
`define XBC_CTRL_RDYEN   5
`define XBC_CTRL_RDYPOL  6
`define XBC_CTRL_RDYASY  7
`define XBC_CTRL_CLKEN   8
`define XBC_CTRL_CS_LO   9
`define XBC_CTRL_CS_HI   10
`define XBC_CTRL_RESET   11'h000

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define XBC_STAT_BUSY    0
`define XBC_STAT_DONE    1
`define XBC_STAT_RWAIT   2

// ----------------------------------------------------------------
// timing config fields (one word per chip select)
// ----------------------------------------------------------------
`define XBC_TC_AB_LO     0
`define XBC_TC_AB_HI     2
`define XBC_TC_C_LO      4
`define XBC_TC_C_HI      5
`define XBC_TC_D         6
`define XBC_TC_E_LO      7
`define XBC_TC_E_HI      11
`define XBC_TC_F_LO      12
`define XBC_TC_F_HI      13
`define XBC_TCFG_RESET   14'h0001

// ----------------------------------------------------------------
// timing and bus response codes
// ----------------------------------------------------------------
`define XBC_PHASE_UNIT_CYC  1
`define XBC_AB_MAX          3'h5
`define XBC_RESP_OKAY       2'h0
`define XBC_RESP_SLVERR     2'h2

`endif

// ==== verification/xbc_cycle_ctrl_tb.sv ====
// self-checking bench for the external bus cycle controller
`timescale 1ns/1ps
`default_nettype none
module xbc_cycle_ctrl_tb;
  logic        clk = 1'h0, rst_n = 1'h0, pol = 1'h1, shm = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, wait_cyc = 8'hC8;
  logic [31:0] wdata = 32'h0, rv;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic [1:0]  br;
  logic [15:0] rd_val = 16'h0000;
  logic [3:0]  cs_seen;
  wire         awready, wready, bvalid, arready, rvalid, rdy, ale;
  wire         ube_n, rd_n, wl_n, wh_n, refclk, s_oe, d_oe;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [3:0]   cs_n;
  wire [23:0]  addr;
  wire [15:0]  s_in, s_out, d_in, d_out, wr_seen;
  integer n_cs, n_ale, n_wl, n_wh, n_ube, n_rd, tick = 0;
  integer n_mismatch = 0, checked = 0, i, base[2];
  int ab[3] = '{1, 2, 5}, pc[3] = '{0, 3, 3}, pd[3] = '{0, 1, 1};
  int pe[3] = '{1, 7, 32}, pf[3] = '{0, 2, 3};
  xbc_cycle_ctrl u_dut (.clk(clk), .rst_n(rst_n), .ce(1'h1),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .chip_select_n(cs_n), .addr_latch_strobe(ale),
    .upper_byte_enable_n(ube_n), .read_strobe_n(rd_n),
    .write_low_n(wl_n), .write_high_n(wh_n),
    .bus_reference_clock_out(refclk), .ready_in(rdy),
    .address_lines(addr), .shared_addr_data_lines_in(s_in),
    .shared_addr_data_lines_out(s_out), .shared_addr_data_lines_oe(s_oe),
    .data_lines_in(d_in), .data_lines_out(d_out), .data_lines_oe(d_oe));
  xbc_ext_mem u_mem (.clk(clk), .rst_n(rst_n), .pol(pol),
    .wait_cyc(wait_cyc), .rd_val(rd_val), .shm(shm), .rd_n(rd_n),
    .wl_n(wl_n), .wh_n(wh_n), .s_out(s_out), .d_out(d_out), .rdy(rdy),
    .s_in(s_in), .d_in(d_in), .wr_seen(wr_seen));
  // ----------------------------------------------------------------
  // clock, bus monitor, timeout
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    tick = tick + 1;
    if (cs_n !== 4'hF) begin
      n_cs = n_cs + 1;
      cs_seen = cs_n;
    end
    n_ale = n_ale + ale;
    n_wl = n_wl + !wl_n;
    n_wh = n_wh + !wh_n;
    n_ube = n_ube + !ube_n;
    n_rd = n_rd + !rd_n;
    if (tick == 20000) begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task results;
    begin
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task cmp(input string nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // address and data offered together, each released when taken
  task axw(input [7:0] a, input [31:0] d);
    integer k;
    logic ah, wh, bh;
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      bh = 1'h0;
      k = 0;
      while (!bh && k < 100) begin
        @(negedge clk);
        ah = awvalid & awready;
        wh = wvalid & wready;
        bh = bvalid & bready;
        br = bresp;
        k = k + 1;
        @(posedge clk);
        if (ah) awvalid <= 1'h0;
        if (wh) wvalid <= 1'h0;
        if (bh) bready <= 1'h0;
      end
      if (!bh) n_mismatch = n_mismatch + 1;
    end
  endtask
  task axr(input [7:0] a, output [31:0] d);
    integer k;
    logic ah, rh;
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      rh = 1'h0;
      k = 0;
      while (!rh && k < 100) begin
        @(negedge clk);
        ah = arvalid & arready;
        rh = rvalid & rready;
        d = rdata;
        br = rresp;
        k = k + 1;
        @(posedge clk);
        if (ah) arvalid <= 1'h0;
        if (rh) rready <= 1'h0;
      end
      if (!rh) n_mismatch = n_mismatch + 1;
    end
  endtask
  function [31:0] tc(input int a, c, d, e, f);
    tc = (f << 12) | ((e - 1) << 7) | (d << 6) | (c << 4) | a;
  endfunction
  // program timing of the selected chip select, start, wait for the end
  task go(input [31:0] c, input [31:0] t);
    integer k;
    begin
      axw(8'h14 + {4'h0, c[10:9], 2'h0}, t);
      {n_cs, n_ale, n_wl, n_wh, n_ube, n_rd} = '0;
      axw(8'h00, c | 32'h1);
      k = 0;
      while (k < 400 && (n_cs == 0 || cs_n !== 4'hF)) begin
        @(negedge clk);
        k = k + 1;
      end
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    axr(8'h00, rv);
    cmp("ctrl", 32'h0, rv);
    axr(8'h14, rv);
    cmp("tcfg0", 32'h1, rv);
    axr(8'h40, rv);
    cmp("unmapped", 32'h2, {30'h0, br});
    shm <= 1'h1;
    axw(8'h08, 32'hC3A5);
    for (i = 0; i < 3; i = i + 1) begin
      axw(8'h04, 32'h5A0000 + i);
      go(32'h12 | (i << 9), tc(ab[i], pc[i], pd[i], pe[i], pf[i]));
      cmp("cs_len", ab[i] + pc[i] + pd[i] + pe[i] + pf[i], n_cs);
      cmp("ale", ab[i], n_ale);
      cmp("wr_lo", pe[i], n_wl);
      cmp("ube", ab[i] + pc[i] + pd[i] + pe[i] + pf[i], n_ube);
      cmp("cs", ~(32'h1 << i) & 32'hF, {28'h0, cs_seen});
      cmp("wdata", 32'hC3A5, {16'h0, wr_seen});
      cmp("addr", 32'h5A0000 + i, {8'h0, addr});
    end
    shm <= 1'h0;
    for (i = 0; i < 2; i = i + 1) begin
      go(32'h6 | (i << 3), tc(1, 0, 0, 2, 0));
      cmp("wr_lo", 2 - 2 * i, n_wl);
      cmp("wr_hi", 2 * i, n_wh);
      cmp("ube", 3 * i, n_ube);
    end
    for (i = 0; i < 2; i = i + 1) begin
      shm <= i;
      rd_val <= 16'h9E61 ^ i;
      go(i << 4, tc(1, 0, 1, 4, 1));
      cmp("rd_len", 5, n_rd);
      axr(8'h0C, rv);
      cmp("rdata", 32'h9E61 ^ i, rv);
    end
    axr(8'h10, rv);
    cmp("done", 32'h2, rv & 32'h2);
    axw(8'h10, 32'h2);
    axr(8'h10, rv);
    cmp("done_clr", 32'h0, rv & 32'h2);
    shm <= 1'h0;
    // waits are compared against a base run, latency itself is free
    for (i = 0; i < 2; i = i + 1) begin
      pol <= i;
      wait_cyc <= 8'h03;
      go(32'h22 | (i << 6), tc(1, 0, 0, 1, 0));
      base[i] = n_wl;
      wait_cyc <= 8'h05;
      go(32'h22 | (i << 6), tc(1, 0, 0, 1, 0));
      cmp("rdy_wait", base[i] + 2, n_wl);
      wait_cyc <= 8'h03;
      go(32'hA2 | (i << 6), tc(1, 0, 0, 1, 0));
      cmp("rdy_async", base[i] + 1, n_wl);
      wait_cyc <= 8'h00;
      go(32'h22 | (i << 6), tc(1, 0, 0, 8, 0));
      cmp("min_access", 8, n_wl);
    end
    cmp("rdy_pol", base[0], base[1]);
    axw(8'h00, 32'h100);
    @(posedge clk);
    #1;
    cmp("refclk_hi", 32'h1, {31'h0, refclk});
    #5;
    cmp("refclk_lo", 32'h0, {31'h0, refclk});
    results;
  end
endmodule
`default_nettype wire

// ==== verification/xbc_ext_mem.sv ====
// behavioural external memory on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module xbc_ext_mem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // settings
  input  wire logic        pol,
  input  wire logic [7:0]  wait_cyc,
  input  wire logic [15:0] rd_val,
  input  wire logic        shm,
  // controller side
  input  wire logic        rd_n,
  input  wire logic        wl_n,
  input  wire logic        wh_n,
  input  wire logic [15:0] s_out,
  input  wire logic [15:0] d_out,
  output logic             rdy,
  output logic [15:0]      s_in,
  output logic [15:0]      d_in,
  output logic [15:0]      wr_seen
);
  logic       rdy_ff;
  logic [7:0] cnt_ff;
  wire wr  = !wl_n || !wh_n;
  wire cmd = !rd_n || wr;
  assign rdy = pol ? rdy_ff : !rdy_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_ff <= 1'h0;
      cnt_ff <= 8'h00;
      s_in <= 16'h0000;
      d_in <= 16'h0000;
      wr_seen <= 16'h0000;
    end else begin
      // ready drops only once the command strobe has risen
      if (!cmd) begin
        rdy_ff <= 1'h0;
        cnt_ff <= 8'h00;
      end else if (cnt_ff >= wait_cyc)
        rdy_ff <= 1'h1;
      else
        cnt_ff <= cnt_ff + 8'h01;
      // released lines toggle so stale data never looks valid
      s_in <= !rd_n ? rd_val : ~s_in;
      d_in <= !rd_n ? rd_val : ~d_in;
      if (wr)
        wr_seen <= shm ? s_out : d_out;
    end
  end
endmodule
`default_nettype wire

// ==== verification/xbc_props.sv ====
// port assertions for the external bus cycle controller
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module xbc_props #(
  parameter NUM_CS = 4
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [NUM_CS-1:0] chip_select_n,
  input wire logic              addr_latch_strobe,
  input wire logic              upper_byte_enable_n,
  input wire logic              read_strobe_n,
  input wire logic              write_low_n,
  input wire logic              write_high_n,
  input wire logic              shared_addr_data_lines_oe,
  input wire logic              data_lines_oe,
  input wire logic              s_bvalid,
  input wire logic              s_bready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr   = !write_low_n || !write_high_n;
  wire cmd  = !read_strobe_n || wr;
  wire idle = &chip_select_n;
  property p_cs_cmd; cmd |-> !idle; endproperty
  a_cs_cmd: assert property (p_cs_cmd)
    else $error("command strobe outside chip select");
  property p_cs_one; $onehot0(~chip_select_n); endproperty
  a_cs_one: assert property (p_cs_one)
    else $error("more than one chip select low");
  property p_cs_stb; cmd && $past(cmd) |-> $stable(chip_select_n);
  endproperty
  a_cs_stb: assert property (p_cs_stb)
    else $error("chip select moved inside a command");
  property p_ale;
    addr_latch_strobe |-> !cmd && !idle && shared_addr_data_lines_oe;
  endproperty
  a_ale: assert property (p_ale)
    else $error("latch strobe outside address phase");
  property p_rw; !(!read_strobe_n && wr); endproperty
  a_rw: assert property (p_rw)
    else $error("read and write strobes together");
  property p_rd_turn;
    !read_strobe_n |-> !shared_addr_data_lines_oe && !data_lines_oe;
  endproperty
  a_rd_turn: assert property (p_rd_turn)
    else $error("data lines driven during read");
  property p_wr_drv; wr |-> shared_addr_data_lines_oe || data_lines_oe;
  endproperty
  a_wr_drv: assert property (p_wr_drv)
    else $error("write strobe without driven data");
  property p_hold; $fell(cmd) |-> ##[0:3] idle; endproperty
  a_hold: assert property (p_hold)
    else $error("hold phase longer than three");
  property p_ube; !upper_byte_enable_n |-> !idle; endproperty
  a_ube: assert property (p_ube)
    else $error("byte enable outside a cycle");
  property p_bhold; s_bvalid && !s_bready |=> s_bvalid; endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
  c_rd: cover property ($fell(read_strobe_n));
  c_wh: cover property ($fell(write_high_n));
  c_ale: cover property ($rose(addr_latch_strobe));
endmodule
bind xbc_cycle_ctrl xbc_props #(.NUM_CS(NUM_CS)) u_props (
  .clk(clk), .rst_n(rst_n), .chip_select_n(chip_select_n),
  .addr_latch_strobe(addr_latch_strobe),
  .upper_byte_enable_n(upper_byte_enable_n),
  .read_strobe_n(read_strobe_n), .write_low_n(write_low_n),
  .write_high_n(write_high_n),
  .shared_addr_data_lines_oe(shared_addr_data_lines_oe),
  .data_lines_oe(data_lines_oe), .s_bvalid(s_bvalid),
  .s_bready(s_bready));
`default_nettype wire
